// ### verilog/stsr_status_srq.sv
// Status byte, event registers, service request, error queue and reading transfer.
//
// Functional notes
// - Status byte summarises the standard event and questionable data groups.
// - Event bits latch on their condition and stay set until cleared.
// - Reading an event register or clear-status clears that event register.
// - Device reset and device clear leave latched event bits alone.
// - Event register read returns the binary weighted sum of set bits.
// - Group summary is OR of event bits whose enable bit is set.
// - Masks are read/write; reading or clear-status never alters them.
// - Status preset clears the questionable enable mask.
// - Message-available follows output buffer contents, clears when all read.
// - Summary bits never latch; clearing an event register clears its summary.
// - Status byte: bits 0,1,2,7 zero; 8 ques, 16 mav, 32 std, 64 rqs.
// - Clear-status clears the ques, std and rqs bits; event read clears its summary bit, and rqs once no masked summary remains.
// - Rising request-service bit asserts the service request line via mask.
// - Request-service clears only by serial poll, clear-status or reading the causing register.
// - Serial poll reads status byte and clears only request-service.
// - Error queue holds 20 entries, returned first in first out.
// - Questionable bits: 0 volt, 1 current, 9 ohms, 11 low, 12 high limit.
// - Standard bits: 0 opc, 2 query, 3 device, 4 exec, 5 command, 7 power-on.
// - Fetch moves stored readings to the output buffer.
// - Report how many readings sit in reading memory.
// - Self-test query runs self-test, answers 0 on pass, 1 on fail.
// - Operation complete sets after all prior commands ran; unused bits zero.
`timescale 1ns/1ps

module stsr_status_srq
  import stsr_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic power_on_clear_setting_i,
  input wire stsr_cmd_t cmd_i,
  input wire stsr_evt_t evt_i,
  input wire logic cmds_done_i,
  input wire logic dev_clear_i,
  input wire logic spoll_i,
  input wire logic outbuf_read_i,
  input wire logic selftest_done_i,
  input wire logic selftest_fail_i,
  output stsr_resp_t resp_o,
  output stsr_resp_t poll_o,
  output logic [7:0] status_byte_o,
  output logic output_pending_flag_o,
  output logic srq_o,
  output logic selftest_run_o
);

  // Masked OR of an event register against its enable mask.
  function automatic logic summary_of(input logic [15:0] ev, input logic [15:0] en);
    summary_of = |(ev & en);
  endfunction

  logic [15:0] qev_r;
  logic [15:0] qev_nxt;
  logic [15:0] qen_r;
  logic [7:0] sev_r;
  logic [7:0] sev_nxt;
  logic [7:0] sen_r;
  logic [7:0] sre_r;
  logic [7:0] sre_nxt;
  logic rqs_r;
  logic rqs_nxt;
  logic req_r;
  logic req_nxt;
  logic opc_pend_r;
  logic [STSR_CNT_W-1:0] out_cnt_r;
  logic [STSR_CNT_W-1:0] out_cnt_nxt;
  logic [9:0] rdg_cnt_r;
  logic [STSR_ERR_W-1:0] errq_mem [STSR_ERRQ_DEPTH];
  logic [4:0] errq_head_r;
  logic [4:0] errq_tail_r;
  logic [4:0] errq_cnt_r;
  stsr_tst_t tst_state_r;
  logic [7:0] stb_nxt;

  logic take;
  logic do_cls;
  logic do_preset;
  logic do_opc;
  logic rd_qev;
  logic rd_sev;
  logic do_fetch;
  logic do_err;
  logic do_tst;
  logic reply;
  logic err_push_ok;
  logic err_pop_ok;
  logic opc_set;
  logic ques_sum_nxt;
  logic std_sum_nxt;
  logic mav_nxt;

  // Commands are refused while the self-test runs so its answer never collides.
  assign take = cmd_i.valid && (tst_state_r == STSR_ST_IDLE);
  assign do_cls = take && (cmd_i.op == STSR_OP_CLS);
  assign do_preset = take && (cmd_i.op == STSR_OP_PRESET);
  assign do_opc = take && (cmd_i.op == STSR_OP_OPC);
  assign rd_qev = take && (cmd_i.op == STSR_OP_RD_QEV);
  assign rd_sev = take && (cmd_i.op == STSR_OP_RD_SEV);
  assign do_fetch = take && (cmd_i.op == STSR_OP_FETCH);
  assign do_err = take && cmd_i.errq;
  assign do_tst = take && cmd_i.selftest;
  assign err_pop_ok = do_err && (errq_cnt_r != 5'd0);
  assign err_push_ok = evt_i.err_push && ((errq_cnt_r != 5'(STSR_ERRQ_DEPTH)) || err_pop_ok);
  assign opc_set = (opc_pend_r || do_opc) && cmds_done_i;

  // A reply is one query answer placed in the output buffer.
  always_comb begin
    reply = 1'b0;
    if (take) begin
      unique case (cmd_i.op)
        STSR_OP_RD_QEV, STSR_OP_RD_QEN, STSR_OP_RD_SEV, STSR_OP_RD_SEN,
        STSR_OP_RD_SRE, STSR_OP_RD_STB, STSR_OP_POINTS: begin
          reply = 1'b1;
        end
        default: begin
          reply = 1'b0;
        end
      endcase
      if (cmd_i.errq) begin
        reply = 1'b1;
      end
    end
    if (tst_state_r == STSR_ST_RUN && selftest_done_i) begin
      reply = 1'b1;
    end
  end

  // Event latches: a new condition in the clearing cycle survives the clear.
  always_comb begin
    qev_nxt = qev_r;
    sev_nxt = sev_r;
    if (do_cls || rd_qev) begin
      qev_nxt = STSR_QEV_RST;
    end
    if (do_cls || rd_sev) begin
      sev_nxt = STSR_MASK_CLR;
    end
    qev_nxt = qev_nxt | (evt_i.ques & STSR_QEV_USED);
    sev_nxt = sev_nxt | (evt_i.std & STSR_SEV_USED);
    if (opc_set) begin
      sev_nxt[STSR_SB_OPC] = 1'b1;
    end
  end

  always_comb begin
    sre_nxt = sre_r;
    if (take && cmd_i.op == STSR_OP_WR_SRE) begin
      sre_nxt = cmd_i.data[7:0] & STSR_SRE_USED;
    end
  end

  // Output buffer message count: replies and fetched readings in, reads out.
  always_comb begin
    out_cnt_nxt = out_cnt_r;
    if (dev_clear_i) begin
      out_cnt_nxt = '0;
    end else begin
      if (do_fetch) begin
        out_cnt_nxt = out_cnt_nxt + STSR_CNT_W'(rdg_cnt_r);
      end
      if (reply && out_cnt_nxt != STSR_OUT_MAX) begin
        out_cnt_nxt = out_cnt_nxt + 1'b1;
      end
      if (outbuf_read_i && out_cnt_nxt != '0) begin
        out_cnt_nxt = out_cnt_nxt - 1'b1;
      end
    end
  end

  // Summary bits are recomputed every cycle from the latches, never stored.
  assign ques_sum_nxt = summary_of(qev_nxt, qen_r);
  assign std_sum_nxt = summary_of({8'h00, sev_nxt}, {8'h00, sen_r});
  assign mav_nxt = (out_cnt_nxt != '0);
  assign req_nxt = |({std_sum_nxt, mav_nxt, ques_sum_nxt} & sre_nxt[5:3]);

  always_comb begin
    stb_nxt = 8'h00;
    stb_nxt[STSR_YB_QUES] = ques_sum_nxt;
    stb_nxt[STSR_YB_MAV] = mav_nxt;
    stb_nxt[STSR_YB_STD] = std_sum_nxt;
    stb_nxt[STSR_YB_RQS] = rqs_nxt;
  end

  // Request service sets on a rising masked summary and wins over a clear.
  always_comb begin
    rqs_nxt = rqs_r;
    if (spoll_i || do_cls) begin
      rqs_nxt = 1'b0;
    end else if ((rd_qev || rd_sev) && !req_nxt) begin
      rqs_nxt = 1'b0;
    end
    if (req_nxt && !req_r) begin
      rqs_nxt = 1'b1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      qev_r <= STSR_QEV_RST;
      sev_r <= STSR_SEV_RST;
    end else begin
      qev_r <= qev_nxt;
      sev_r <= sev_nxt;
    end
  end

  // Reset is power-on; the SRE and standard masks keep their value unless the clear setting is 1; the questionable mask always clears.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      if (power_on_clear_setting_i) begin
        sre_r <= STSR_MASK_CLR;
        sen_r <= STSR_MASK_CLR;
      end
      qen_r <= STSR_QEN_RST;
    end else begin
      sre_r <= sre_nxt;
      if (take && cmd_i.op == STSR_OP_WR_SEN) begin
        sen_r <= cmd_i.data[7:0] & STSR_SEV_USED;
      end
      if (do_preset) begin
        qen_r <= STSR_QEN_RST;
      end else if (take && cmd_i.op == STSR_OP_WR_QEN) begin
        qen_r <= cmd_i.data & STSR_QEV_USED;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rqs_r <= 1'b0;
      req_r <= 1'b0;
      srq_o <= 1'b0;
      status_byte_o <= 8'h00;
      output_pending_flag_o <= 1'b0;
    end else begin
      rqs_r <= rqs_nxt;
      req_r <= req_nxt;
      srq_o <= rqs_nxt;
      status_byte_o <= stb_nxt;
      output_pending_flag_o <= mav_nxt;
    end
  end

  // Serial poll answers one cycle after the poll and disturbs nothing but the request bit.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      poll_o <= '0;
    end else begin
      poll_o.valid <= spoll_i;
      poll_o.data <= {8'h00, stb_nxt[7:STSR_YB_RQS+1], rqs_r, stb_nxt[STSR_YB_STD:0]};
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i || dev_clear_i) begin
      opc_pend_r <= 1'b0;
    end else if (opc_set) begin
      opc_pend_r <= 1'b0;
    end else if (do_opc) begin
      opc_pend_r <= 1'b1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      out_cnt_r <= '0;
    end else begin
      out_cnt_r <= out_cnt_nxt;
    end
  end

  // Reading memory count; a store in the fetch cycle stays in memory.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rdg_cnt_r <= '0;
    end else if (do_fetch) begin
      rdg_cnt_r <= {9'h000, evt_i.rdg_store};
    end else if (evt_i.rdg_store && rdg_cnt_r != 10'(STSR_RDG_DEPTH)) begin
      rdg_cnt_r <= rdg_cnt_r + 1'b1;
    end
  end

  // Error queue keeps codes only; text of up to STSR_ERR_CHARS lives in firmware.
  always_ff @(posedge mclk_i) begin
    if (err_push_ok) begin
      errq_mem[errq_tail_r] <= evt_i.err_code;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      errq_head_r <= '0;
      errq_tail_r <= '0;
      errq_cnt_r <= '0;
    end else begin
      if (err_push_ok) begin
        errq_tail_r <= (errq_tail_r == 5'(STSR_ERRQ_DEPTH - 1)) ? 5'd0 : errq_tail_r + 1'b1;
      end
      if (err_pop_ok) begin
        errq_head_r <= (errq_head_r == 5'(STSR_ERRQ_DEPTH - 1)) ? 5'd0 : errq_head_r + 1'b1;
      end
      if (err_push_ok && !err_pop_ok) begin
        errq_cnt_r <= errq_cnt_r + 1'b1;
      end else if (err_pop_ok && !err_push_ok) begin
        errq_cnt_r <= errq_cnt_r - 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      tst_state_r <= STSR_ST_IDLE;
      selftest_run_o <= 1'b0;
    end else begin
      selftest_run_o <= 1'b0;
      unique case (tst_state_r)
        STSR_ST_IDLE: begin
          if (do_tst) begin
            tst_state_r <= STSR_ST_RUN;
            selftest_run_o <= 1'b1;
          end
        end
        STSR_ST_RUN: begin
          if (selftest_done_i) begin
            tst_state_r <= STSR_ST_IDLE;
          end
        end
      endcase
    end
  end

  // Query answers, one cycle after the command is taken.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      resp_o <= '0;
    end else begin
      resp_o.valid <= reply;
      resp_o.data <= 16'h0000;
      if (tst_state_r == STSR_ST_RUN && selftest_done_i) begin
        resp_o.data <= selftest_fail_i ? STSR_TST_FAIL : STSR_TST_PASS;
      end else if (take && cmd_i.errq) begin
        resp_o.data <= err_pop_ok ? errq_mem[errq_head_r] : 16'h0000;
      end else if (take) begin
        unique case (cmd_i.op)
          STSR_OP_RD_QEV: resp_o.data <= qev_r;
          STSR_OP_RD_SEV: resp_o.data <= {8'h00, sev_r};
          STSR_OP_RD_QEN: resp_o.data <= qen_r;
          STSR_OP_RD_SEN: resp_o.data <= {8'h00, sen_r};
          STSR_OP_RD_SRE: resp_o.data <= {8'h00, sre_r};
          STSR_OP_RD_STB: resp_o.data <= {8'h00, stb_nxt};
          STSR_OP_POINTS: resp_o.data <= {6'h00, rdg_cnt_r};
          default: resp_o.data <= 16'h0000;
        endcase
      end
    end
  end

endmodule

// ### verilog/stsr_pkg.sv
// Shared constants and types for the status reporting and service-request block.
package stsr_pkg;

  // Register widths.
  localparam int STSR_QW = 16;
  localparam int STSR_BW = 8;

  // Questionable data event bit positions.
  localparam int STSR_QB_VOLT_OVLD = 0;
  localparam int STSR_QB_CURR_OVLD = 1;
  localparam int STSR_QB_OHMS_OVLD = 9;
  localparam int STSR_QB_LIM_LO = 11;
  localparam int STSR_QB_LIM_HI = 12;
  localparam logic [15:0] STSR_QEV_USED = 16'h1A03;

  // Standard event bit positions.
  localparam int STSR_SB_OPC = 0;
  localparam int STSR_SB_QUERY_ERR = 2;
  localparam int STSR_SB_DEV_ERR = 3;
  localparam int STSR_SB_EXEC_ERR = 4;
  localparam int STSR_SB_CMD_ERR = 5;
  localparam int STSR_SB_PON = 7;
  localparam logic [7:0] STSR_SEV_USED = 8'hBD;

  // Status byte bit positions.
  localparam int STSR_YB_QUES = 3;
  localparam int STSR_YB_MAV = 4;
  localparam int STSR_YB_STD = 5;
  localparam int STSR_YB_RQS = 6;
  localparam logic [7:0] STSR_SRE_USED = 8'h38;

  // Values after power-on.
  localparam logic [15:0] STSR_QEV_RST = 16'h0000;
  localparam logic [15:0] STSR_QEN_RST = 16'h0000;
  localparam logic [7:0] STSR_SEV_RST = 8'h80;
  localparam logic [7:0] STSR_MASK_CLR = 8'h00;

  // Error queue, reading memory and output buffer sizes.
  localparam int STSR_ERRQ_DEPTH = 20;
  localparam int STSR_ERR_CHARS = 80;
  localparam int STSR_ERR_W = 16;
  localparam int STSR_RDG_DEPTH = 512;
  localparam int STSR_CNT_W = 11;
  localparam logic [10:0] STSR_OUT_MAX = 11'h7FF;

  // Self-test answers.
  localparam logic [15:0] STSR_TST_PASS = 16'h0000;
  localparam logic [15:0] STSR_TST_FAIL = 16'h0001;

  typedef enum logic [3:0] {
    STSR_OP_NONE,
    STSR_OP_CLS,
    STSR_OP_RST,
    STSR_OP_PRESET,
    STSR_OP_OPC,
    STSR_OP_RD_QEV,
    STSR_OP_RD_QEN,
    STSR_OP_WR_QEN,
    STSR_OP_RD_SEV,
    STSR_OP_RD_SEN,
    STSR_OP_WR_SEN,
    STSR_OP_RD_SRE,
    STSR_OP_WR_SRE,
    STSR_OP_RD_STB,
    STSR_OP_FETCH,
    STSR_OP_POINTS
  } stsr_op_t;

  typedef struct packed {
    logic valid;
    stsr_op_t op;
    logic errq;
    logic selftest;
    logic [15:0] data;
  } stsr_cmd_t;

  typedef struct packed {
    logic [15:0] ques;
    logic [7:0] std;
    logic err_push;
    logic [15:0] err_code;
    logic rdg_store;
  } stsr_evt_t;

  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } stsr_resp_t;

  typedef enum logic [0:0] {
    STSR_ST_IDLE,
    STSR_ST_RUN
  } stsr_tst_t;

endpackage

// ### testbench/stsr_props.sv
// Assertions on the status byte, service request and answer timing.
`timescale 1ns/1ps
module stsr_props
  import stsr_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire stsr_cmd_t cmd_i,
  input wire stsr_evt_t evt_i,
  input wire logic spoll_i,
  input wire logic selftest_done_i,
  input wire stsr_resp_t resp_o,
  input wire stsr_resp_t poll_o,
  input wire logic [7:0] status_byte_o,
  input wire logic output_pending_flag_o,
  input wire logic srq_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  logic busy_r;
  logic take;
  logic calm;
  assign take = cmd_i.valid && !busy_r;
  assign calm = !cmd_i.valid && evt_i.ques == 16'h0000 && evt_i.std == 8'h00;
  // Mirrors the self-test window, since commands in it are dropped without an answer.
  always_ff @(posedge mclk_i) begin
    if (rst_i || selftest_done_i) begin
      busy_r <= 1'b0;
    end else if (take && cmd_i.selftest) begin
      busy_r <= 1'b1;
    end
  end
  spare_zero_a:
    assert property (status_byte_o[7] == 1'b0 && status_byte_o[2:0] == 3'h0)
    else $error("status byte spare bits set");
  mav_flag_a:
    assert property (status_byte_o[4] == output_pending_flag_o)
    else $error("message available flag differs");
  srq_raise_a:
    assert property (status_byte_o[6] |-> ##[0:1] srq_o)
    else $error("service request line not raised");
  poll_answer_a:
    assert property (spoll_i |=> poll_o.valid && poll_o.data[15:8] == 8'h00)
    else $error("serial poll not answered");
  poll_clear_a:
    assert property (spoll_i && calm |-> ##[1:2] !status_byte_o[6] ##[0:2] !srq_o)
    else $error("serial poll left request service set");
  read_answer_a:
    assert property (take && (cmd_i.errq || cmd_i.op inside {STSR_OP_RD_QEV, STSR_OP_RD_QEN,
      STSR_OP_RD_SEV, STSR_OP_RD_SEN, STSR_OP_RD_SRE, STSR_OP_RD_STB, STSR_OP_POINTS})
      |=> resp_o.valid)
    else $error("query not answered");
  refuse_a:
    assert property (cmd_i.valid && busy_r && !selftest_done_i |=> !resp_o.valid)
    else $error("command answered during self-test");
  sev_clear_a:
    assert property (take && cmd_i.op == STSR_OP_RD_SEV && evt_i.std == 8'h00
      |=> !status_byte_o[5])
    else $error("standard summary kept after read");
  cls_clear_a:
    assert property (take && cmd_i.op == STSR_OP_CLS && evt_i.ques == 16'h0000
      && evt_i.std == 8'h00 |=> (status_byte_o & 8'h68) == 8'h00)
    else $error("clear status left summary bits");
  mask_readback_a:
    assert property ((take && cmd_i.op == STSR_OP_WR_SEN) ##1 (take && cmd_i.op == STSR_OP_RD_SEN)
      |=> resp_o.data == {8'h00, $past(cmd_i.data[7:0], 2) & STSR_SEV_USED})
    else $error("standard mask readback wrong");
  poll_seen_c: cover property (spoll_i);
  selftest_seen_c: cover property (take && cmd_i.selftest);
  srq_ques_c: cover property (srq_o && status_byte_o[3]);
endmodule

// ### testbench/stsr_bus_ctrl.sv
// Behavioural bus controller that answers a service request with one serial poll.
`timescale 1ns/1ps
module stsr_bus_ctrl (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic srq_i,
  input wire logic auto_i,
  input wire logic slow_i,
  input wire logic done_i,
  output logic spoll_o = 1'b0
);
  int wait_r;
  int hold_r;
  // The hold count keeps the poll low for three cycles after each poll; the line falls at the falling edge after the rising edge that takes it.
  always @(negedge mclk_i) begin
    if (rst_i || !auto_i) begin
      spoll_o <= 1'b0;
      wait_r <= 0;
      hold_r <= 0;
    end else if (hold_r != 0) begin
      spoll_o <= 1'b0;
      hold_r <= hold_r - 1;
    end else if (srq_i && done_i && wait_r >= (slow_i ? 4 : 0)) begin
      spoll_o <= 1'b1;
      hold_r <= 3;
      wait_r <= 0;
    end else begin
      spoll_o <= 1'b0;
      if (srq_i) begin
        wait_r <= wait_r + 1;
      end
    end
  end
endmodule

// ### testbench/stsr_status_srq_bench.sv
// Self-checking bench for the status reporting and service-request block.
`timescale 1ns/1ps
`define C(n, e, g) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end
module stsr_status_srq_bench import stsr_pkg::*;;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic poc = 1'b1;
  stsr_cmd_t cmd_i = '0;
  stsr_evt_t evt_i = '0;
  logic done_all = 1'b1;
  logic dev_clr = 1'b0;
  logic ob_rd = 1'b0;
  logic st_done = 1'b0;
  logic st_fail = 1'b0;
  logic auto = 1'b0;
  logic slow = 1'b0;
  logic spoll_i;
  stsr_resp_t resp_o;
  stsr_resp_t poll_o;
  logic [7:0] status_byte_o;
  logic output_pending_flag_o;
  logic srq_o;
  logic selftest_run_o;
  logic [7:0] last_poll = 8'h00;
  int n_polls = 0;
  int n_errors = 0;
  int n_tests = 0;
  int k;
  always #10 mclk_i = ~mclk_i;
  always @(posedge mclk_i) begin
    if (poll_o.valid === 1'b1) begin
      last_poll <= poll_o.data[7:0];
      n_polls <= n_polls + 1;
    end
  end
  stsr_status_srq stsr_status_srq_i (.mclk_i(mclk_i), .rst_i(rst_i),
    .power_on_clear_setting_i(poc), .cmd_i(cmd_i), .evt_i(evt_i), .cmds_done_i(done_all),
    .dev_clear_i(dev_clr), .spoll_i(spoll_i), .outbuf_read_i(ob_rd),
    .selftest_done_i(st_done), .selftest_fail_i(st_fail), .resp_o(resp_o), .poll_o(poll_o),
    .status_byte_o(status_byte_o), .output_pending_flag_o(output_pending_flag_o),
    .srq_o(srq_o), .selftest_run_o(selftest_run_o));
  stsr_bus_ctrl stsr_bus_ctrl_i (.mclk_i(mclk_i), .rst_i(rst_i), .srq_i(srq_o),
    .auto_i(auto), .slow_i(slow), .done_i(done_all), .spoll_o(spoll_i));
  task automatic close_out();
    $display("errors %0d checks %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge mclk_i);
  endtask
  task automatic pulse(ref logic s);
    @(negedge mclk_i);
    s = 1'b1;
    @(negedge mclk_i);
    s = 1'b0;
  endtask
  task automatic x(input stsr_op_t op, input logic [15:0] d, input logic eq, input logic st,
    input logic chk, input logic [15:0] e);
    @(negedge mclk_i);
    cmd_i = '{1'b1, op, eq, st, d};
    @(negedge mclk_i);
    cmd_i.valid = 1'b0;
    // The answer stands for one cycle only, so it is looked at right after the taking edge.
    if (chk) `C("answer", {1'b1, e}, {resp_o.valid, resp_o.data})
    @(negedge mclk_i);
  endtask
  task automatic rd(input stsr_op_t op, input logic [15:0] e);
    x(op, 16'h0000, 1'b0, 1'b0, 1'b1, e);
  endtask
  task automatic op(input stsr_op_t o);
    x(o, 16'h0000, 1'b0, 1'b0, 1'b0, 16'h0000);
  endtask
  task automatic wr_rd(input stsr_op_t w, input stsr_op_t r, input logic [15:0] d,
    input logic [15:0] e);
    @(negedge mclk_i);
    cmd_i = '{1'b1, w, 1'b0, 1'b0, d};
    @(negedge mclk_i);
    cmd_i.op = r;
    @(negedge mclk_i);
    cmd_i.valid = 1'b0;
    `C("readback", {1'b1, e}, {resp_o.valid, resp_o.data})
    @(negedge mclk_i);
  endtask
  task automatic evp(input stsr_evt_t e);
    @(negedge mclk_i);
    evt_i = e;
    @(negedge mclk_i);
    evt_i = '0;
    tick(2);
  endtask
  task automatic ev(input logic [15:0] q, input logic [7:0] s);
    evp('{q, s, 1'b0, 16'h0000, 1'b0});
  endtask
  // Bit 4 is masked out because every query reply also lands in the output buffer.
  task automatic sb(input logic [7:0] e);
    tick(2);
    `C("status", e, status_byte_o & 8'hef)
  endtask
  initial begin
    tick(8);
    rst_i = 1'b0;
    rd(STSR_OP_RD_SEV, 16'h0080);
    rd(STSR_OP_RD_SEV, 16'h0000);
    rd(STSR_OP_RD_QEN, 16'h0000);
    wr_rd(STSR_OP_WR_SEN, STSR_OP_RD_SEN, 16'hffff, 16'h00bd);
    wr_rd(STSR_OP_WR_QEN, STSR_OP_RD_QEN, 16'hffff, 16'h1a03);
    wr_rd(STSR_OP_WR_SRE, STSR_OP_RD_SRE, 16'hffff, 16'h0038);
    // Message available stays out of the mask, since every reply keeps it set.
    wr_rd(STSR_OP_WR_SRE, STSR_OP_RD_SRE, 16'h0028, 16'h0028);
    for (int b = 0; b < 16; b++) begin
      ev(16'h0001 << b, 8'h01 << b);
      rd(STSR_OP_RD_QEV, 16'h1a03 & (16'h0001 << b));
      rd(STSR_OP_RD_SEV, 16'h00bd & (16'h0001 << b));
    end
    ev(16'h0001, 8'h00);
    ev(16'h0200, 8'h00);
    rd(STSR_OP_RD_QEV, 16'h0201);
    for (int s = 0; s < 2; s++) begin
      slow = s[0];
      auto = 1'b1;
      k = n_polls;
      ev(16'h0800, 8'h00);
      for (int w = 0; w < 20 && n_polls == k; w++) tick(1);
      if (n_polls == k) begin
        n_errors++;
        close_out();
      end
      `C("poll", 8'h48, last_poll & 8'hef)
      sb(8'h08);
      `C("srq", 1'b0, srq_o)
      auto = 1'b0;
      rd(STSR_OP_RD_QEV, 16'h0800);
      sb(8'h00);
    end
    ev(16'h0001, 8'h10);
    sb(8'h68);
    `C("srq", 1'b1, srq_o)
    rd(STSR_OP_RD_STB, 16'h0078);
    rd(STSR_OP_RD_SEV, 16'h0010);
    sb(8'h48);
    rd(STSR_OP_RD_QEV, 16'h0001);
    sb(8'h00);
    `C("srq", 1'b0, srq_o)
    ev(16'h1000, 8'h08);
    pulse(dev_clr);
    op(STSR_OP_RST);
    sb(8'h68);
    op(STSR_OP_CLS);
    sb(8'h00);
    rd(STSR_OP_RD_QEV, 16'h0000);
    rd(STSR_OP_RD_SEN, 16'h00bd);
    op(STSR_OP_PRESET);
    rd(STSR_OP_RD_QEN, 16'h0000);
    wr_rd(STSR_OP_WR_SRE, STSR_OP_RD_SRE, 16'h0000, 16'h0000);
    ev(16'h0000, 8'h20);
    sb(8'h20);
    op(STSR_OP_CLS);
    pulse(dev_clr);
    tick(2);
    `C("mav", 1'b0, output_pending_flag_o)
    repeat (3) evp('{16'h0000, 8'h00, 1'b0, 16'h0000, 1'b1});
    rd(STSR_OP_POINTS, 16'h0003);
    op(STSR_OP_FETCH);
    rd(STSR_OP_POINTS, 16'h0000);
    for (int i = 0; i < 5; i++) begin
      `C("mav", 1'b1, status_byte_o[4])
      pulse(ob_rd);
      tick(1);
    end
    `C("mav", 1'b0, output_pending_flag_o)
    for (int i = 1; i <= 21; i++) evp('{16'h0000, 8'h00, 1'b1, i[15:0], 1'b0});
    for (int i = 1; i <= 21; i++) x(STSR_OP_NONE, 16'h0000, 1'b1, 1'b0, 1'b1,
      (i <= 20) ? i[15:0] : 16'h0000);
    done_all = 1'b0;
    op(STSR_OP_OPC);
    rd(STSR_OP_RD_SEV, 16'h0000);
    done_all = 1'b1;
    tick(2);
    rd(STSR_OP_RD_SEV, 16'h0001);
    for (int f = 0; f < 2; f++) begin
      @(negedge mclk_i);
      cmd_i = '{1'b1, STSR_OP_NONE, 1'b0, 1'b1, 16'h0000};
      @(negedge mclk_i);
      cmd_i.valid = 1'b0;
      for (int w = 0; w < 8 && selftest_run_o !== 1'b1; w++) tick(1);
      `C("run", 1'b1, selftest_run_o)
      x(STSR_OP_WR_SEN, 16'h0000, 1'b0, 1'b0, 1'b0, 16'h0000);
      st_fail = f[0];
      pulse(st_done);
      `C("selftest", {1'b1, 15'h0000, f[0]}, {resp_o.valid, resp_o.data})
      rd(STSR_OP_RD_SEN, 16'h00bd);
    end
    // A second power-on with the clear setting at 0 must keep both masks.
    x(STSR_OP_WR_SRE, 16'h0020, 1'b0, 1'b0, 1'b0, 16'h0000);
    poc = 1'b0;
    @(negedge mclk_i);
    rst_i = 1'b1;
    tick(2);
    rst_i = 1'b0;
    rd(STSR_OP_RD_SRE, 16'h0020);
    rd(STSR_OP_RD_SEN, 16'h00bd);
    rd(STSR_OP_RD_SEV, 16'h0080);
    close_out();
  end
endmodule
bind stsr_status_srq stsr_props stsr_props_i (.mclk_i(mclk_i), .rst_i(rst_i), .cmd_i(cmd_i),
  .evt_i(evt_i), .spoll_i(spoll_i), .selftest_done_i(selftest_done_i), .resp_o(resp_o),
  .poll_o(poll_o), .status_byte_o(status_byte_o),
  .output_pending_flag_o(output_pending_flag_o), .srq_o(srq_o));
